// ==== pkg/spc_defines.vh ====
/*
 * spc_defines.vh: bit positions, reset values and encodings shared by the
 * scsi parity control block and its lane checker.
 * assumes: included by bare name from design files under src/.
 */
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// first_scsi_control_reg
`define SPC_CTL0_ATN_ON_ERR   1
`define SPC_CTL0_CHECK_ODD    3
// second_scsi_control_reg
`define SPC_CTL1_EVEN_SENSE   2
`define SPC_CTL1_NO_HALT      5
// first_scsi_irq_enable_reg / first_scsi_irq_status_reg
`define SPC_SIRQ_PARITY       0
// status registers
`define SPC_STAT_LINE         0
`define SPC_STAT_LATCHED      3
// fourth_chip_test_reg
`define SPC_TEST4_MASTER_CHK  3
// dma_status_reg / dma_irq_enable_reg
`define SPC_DMA_MASTER_PERR   6

`define SPC_REG_RESET         8'h00
`define SPC_BYTE_W            8
`define SPC_WORD_W            16

`endif

// ==== src/spc_lane.v ====
/*
 * spc_lane.v: parity generation and odd-parity check for one byte lane.
 * assumes: bus data and parity already converted to active-high by caller.
 */
`timescale 1ns/1ps
`include "spc_defines.vh"

module spc_lane (
  // send side
  input  wire [7:0] tx_byte,
  input  wire       even_sense,
  input  wire       force_bad,
  output wire       tx_parity,
  // receive side
  input  wire [7:0] rx_byte,
  input  wire       rx_parity,
  output wire       rx_odd_parity,
  output wire       rx_error
);

  // odd parity bit: makes the nine bits hold an odd count of ones
  assign rx_odd_parity = ~(^rx_byte);
  // parity always generated; sense picks odd or even, force_bad inverts
  assign tx_parity     = (~(^tx_byte)) ^ even_sense ^ force_bad;
  assign rx_error      = (^{rx_byte, rx_parity}) == 1'b0;

endmodule

// ==== src/spc_parity_ctrl.v ====
/*
 * spc_parity_ctrl.v: scsi parity generation, checking and error handling
 * for one scsi function, plus pci master data-phase parity error tracking.
 * assumes: single clock, all inputs synchronous; scsi pins active low,
 * control bits held by the surrounding register file and passed as ports.
 */
// What this block does
// - initiator with atn-on-error set asserts attention on scsi parity error.
// - check-odd enable turns on odd parity checking of received bytes.
// - even-sense select picks the parity sense driven with sent data.
// - parity always generated on send; odd when select 0, even when 1.
// - a byte can be sent with deliberately wrong parity.
// - target with no-halt flag set defers its halt on parity error to transfer end.
// - parity irq enable decides whether a scsi parity error interrupts.
// - parity error status flag sets on every detected scsi parity error.
// - first status bit 0 shows low-lane parity line, active high.
// - third status bit 0 shows high-lane parity line, active high.
// - master parity check enable gates pci master data-phase checking.
// - master data parity error flag sets when target signals parity error.
// - master parity irq enable clear: flag still sets, no pci interrupt.
// - no-halt 0, irq 0: halt in both modes, no interrupt.
// - no-halt 0, irq 1: halt in target mode, interrupt in both.
// - no-halt 1: target defers halt to transfer end; irq per enable.
// - all scsi bus signals including parity lines are active low.
`timescale 1ns/1ps
`include "spc_defines.vh"

module spc_parity_ctrl (
  // clock and reset
  input  wire        clock,
  input  wire        rst_b,
  input  wire        clk_en,
  // control registers
  input  wire [7:0]  first_scsi_control_reg,
  input  wire [7:0]  second_scsi_control_reg,
  input  wire [7:0]  first_scsi_irq_enable_reg,
  input  wire [7:0]  fourth_chip_test_reg,
  input  wire [7:0]  dma_irq_enable_reg,
  // mode and transfer
  input  wire        is_initiator,
  input  wire        is_target,
  input  wire        wide_bus,
  input  wire        transfer_end,
  input  wire        force_bad_parity,
  // send path
  input  wire        tx_valid,
  input  wire [15:0] tx_data,
  // scsi pins; data, parity and attention active low, rx_strobe and output enables active high
  input  wire [15:0] scsi_data_b_in,
  input  wire        low_lane_check_line_b_in,
  input  wire        high_lane_check_line_b_in,
  input  wire        rx_strobe,
  output reg         low_lane_check_line_b_out,
  output reg         high_lane_check_line_b_out,
  output reg         check_lines_oe,
  output reg         attention_pin_b_out,
  output reg         attention_pin_oe,
  // pci master data phase
  input  wire        master_data_phase,
  input  wire        target_perr,
  // status clear strobes
  input  wire        clear_scsi_status,
  input  wire        clear_dma_status,
  // status registers
  output reg  [7:0]  first_scsi_irq_status_reg,
  output reg  [7:0]  first_scsi_status_reg,
  output reg  [7:0]  second_scsi_status_reg,
  output reg  [7:0]  third_scsi_status_reg,
  output reg  [7:0]  dma_status_reg,
  output reg  [15:0] scsi_input_latch,
  // results
  output reg         halt,
  output reg         scsi_irq,
  output reg         pci_irq
);

  wire check_odd_enable      = first_scsi_control_reg[`SPC_CTL0_CHECK_ODD];
  wire atn_on_error          = first_scsi_control_reg[`SPC_CTL0_ATN_ON_ERR];
  wire even_sense_select     = second_scsi_control_reg[`SPC_CTL1_EVEN_SENSE];
  wire no_halt_target_flag   = second_scsi_control_reg[`SPC_CTL1_NO_HALT];
  wire scsi_bit_error_irq_en = first_scsi_irq_enable_reg[`SPC_SIRQ_PARITY];
  wire master_chk_en         = fourth_chip_test_reg[`SPC_TEST4_MASTER_CHK];
  wire master_irq_en         = dma_irq_enable_reg[`SPC_DMA_MASTER_PERR];

  // bus is active low: invert once at the edge of the block
  wire [15:0] rx_data  = ~scsi_data_b_in;
  wire        rx_par_l = ~low_lane_check_line_b_in;
  wire        rx_par_h = ~high_lane_check_line_b_in;

  wire tx_par_l;
  wire tx_par_h;
  wire odd_l;
  wire odd_h;
  wire err_l;
  wire err_h;

  spc_lane u_lane_low (
    .tx_byte       (tx_data[7:0]),
    .even_sense    (even_sense_select),
    .force_bad     (force_bad_parity),
    .tx_parity     (tx_par_l),
    .rx_byte       (rx_data[7:0]),
    .rx_parity     (rx_par_l),
    .rx_odd_parity (odd_l),
    .rx_error      (err_l)
  );

  spc_lane u_lane_high (
    .tx_byte       (tx_data[15:8]),
    .even_sense    (even_sense_select),
    .force_bad     (force_bad_parity),
    .tx_parity     (tx_par_h),
    .rx_byte       (rx_data[15:8]),
    .rx_parity     (rx_par_h),
    .rx_odd_parity (odd_h),
    .rx_error      (err_h)
  );

  // high lane only counts on a wide bus
  wire parity_err = rx_strobe & check_odd_enable & (err_l | (wide_bus & err_h));
  wire master_err = master_data_phase & master_chk_en & target_perr;

  // target with no-halt waits for end of transfer before halting
  reg  halt_pending;
  wire halt_now_init = parity_err & is_initiator & ~scsi_bit_error_irq_en;
  wire halt_now_tgt  = parity_err & is_target & ~no_halt_target_flag;
  wire pend_set      = parity_err & is_target & no_halt_target_flag;
  wire pend_fire     = (halt_pending | pend_set) & transfer_end;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_lane_check_line_b_out  <= 1'b1;
      high_lane_check_line_b_out <= 1'b1;
      check_lines_oe             <= 1'b0;
      attention_pin_b_out        <= 1'b1;
      attention_pin_oe           <= 1'b0;
      first_scsi_irq_status_reg  <= `SPC_REG_RESET;
      first_scsi_status_reg      <= `SPC_REG_RESET;
      second_scsi_status_reg     <= `SPC_REG_RESET;
      third_scsi_status_reg      <= `SPC_REG_RESET;
      dma_status_reg             <= `SPC_REG_RESET;
      scsi_input_latch           <= 16'h0000;
      halt                       <= 1'b0;
      halt_pending               <= 1'b0;
      scsi_irq                   <= 1'b0;
      pci_irq                    <= 1'b0;
    end else if (clk_en) begin
      // send parity, driven low-true, only while sending
      check_lines_oe             <= tx_valid;
      low_lane_check_line_b_out  <= ~tx_par_l;
      high_lane_check_line_b_out <= ~tx_par_h;

      // live parity line levels, active high
      first_scsi_status_reg[`SPC_STAT_LINE] <= rx_par_l;
      third_scsi_status_reg[`SPC_STAT_LINE] <= rx_par_h;

      if (rx_strobe) begin
        scsi_input_latch <= rx_data;
        second_scsi_status_reg[`SPC_STAT_LATCHED] <= odd_l;
        third_scsi_status_reg[`SPC_STAT_LATCHED]  <= odd_h;
      end

      // set wins over clear on the sticky flags
      if (parity_err)
        first_scsi_irq_status_reg[`SPC_SIRQ_PARITY] <= 1'b1;
      else if (clear_scsi_status)
        first_scsi_irq_status_reg[`SPC_SIRQ_PARITY] <= 1'b0;
      if (master_err)
        dma_status_reg[`SPC_DMA_MASTER_PERR] <= 1'b1;
      else if (clear_dma_status)
        dma_status_reg[`SPC_DMA_MASTER_PERR] <= 1'b0;

      // interrupt lines follow flag and enable
      scsi_irq <= (first_scsi_irq_status_reg[`SPC_SIRQ_PARITY] | parity_err)
                  & scsi_bit_error_irq_en;
      pci_irq  <= (dma_status_reg[`SPC_DMA_MASTER_PERR] | master_err)
                  & master_irq_en;

      // attention held until the error flag is cleared or initiator mode ends
      if (parity_err & is_initiator & atn_on_error) begin
        attention_pin_b_out <= 1'b0;
        attention_pin_oe    <= 1'b1;
      end else if (clear_scsi_status | ~is_initiator) begin
        attention_pin_b_out <= 1'b1;
        attention_pin_oe    <= 1'b0;
      end

      if (pend_fire)
        halt_pending <= 1'b0;
      else if (pend_set)
        halt_pending <= 1'b1;

      // halt is a level until software clears status
      if (halt_now_init | halt_now_tgt | pend_fire)
        halt <= 1'b1;
      else if (clear_scsi_status)
        halt <= 1'b0;
    end
  end

endmodule

// ==== test/spc_assertions.sv ====
/* spc_assertions.sv: port checker for spc_parity_ctrl.
   assumes: bound to the block, one clock, rst_b async low. */
`timescale 1ns/1ps
module spc_assertions (
  input logic clock, rst_b, clk_en, rx_strobe, tx_valid, wide_bus, is_initiator, is_target,
  input logic transfer_end, force_bad_parity, master_data_phase, target_perr, halt, pci_irq,
  input logic low_lane_check_line_b_in, high_lane_check_line_b_in, check_lines_oe,
  input logic low_lane_check_line_b_out, high_lane_check_line_b_out,
  input logic attention_pin_b_out, attention_pin_oe,
  input logic [7:0] first_scsi_control_reg, second_scsi_control_reg, first_scsi_irq_enable_reg,
  input logic [7:0] fourth_chip_test_reg, dma_irq_enable_reg, first_scsi_irq_status_reg,
  input logic [7:0] first_scsi_status_reg, second_scsi_status_reg, third_scsi_status_reg,
  input logic [7:0] dma_status_reg,
  input logic [15:0] tx_data, scsi_data_b_in, scsi_input_latch
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire [15:0] d = ~scsi_data_b_in;
  wire lo_bad = ~^{d[7:0], ~low_lane_check_line_b_in};
  wire hi_bad = wide_bus & ~^{d[15:8], ~high_lane_check_line_b_in};
  wire [1:0] lines = {high_lane_check_line_b_in, low_lane_check_line_b_in};
  wire [1:0] rx_par = {~^d[15:8], ~^d[7:0]};
  wire es = second_scsi_control_reg[2];
  // pin level is inverted odd parity, so it reduces to plain xor of all terms
  wire [1:0] tx_pin = {^{tx_data[15:8], es, force_bad_parity}, ^{tx_data[7:0], es, force_bad_parity}};
  sequence s_err;
    clk_en && rx_strobe && first_scsi_control_reg[3] && (lo_bad || hi_bad);
  endsequence
  property p_flag; s_err |=> first_scsi_irq_status_reg[0]; endproperty
  a_flag: assert property (p_flag) else $error("parity flag missed");
  property p_tx; clk_en && tx_valid |=> check_lines_oe && {high_lane_check_line_b_out,
    low_lane_check_line_b_out} == $past(tx_pin); endproperty
  a_tx: assert property (p_tx) else $error("sent parity wrong");
  property p_line; clk_en |=> {third_scsi_status_reg[0], first_scsi_status_reg[0]} == ~$past(lines);
  endproperty
  a_line: assert property (p_line) else $error("line status wrong");
  property p_latch; clk_en && rx_strobe |=> scsi_input_latch == ~$past(scsi_data_b_in) &&
    {third_scsi_status_reg[3], second_scsi_status_reg[3]} == $past(rx_par); endproperty
  a_latch: assert property (p_latch) else $error("latched parity wrong");
  property p_atn; s_err ##0 is_initiator && first_scsi_control_reg[1] |=>
    !attention_pin_b_out && attention_pin_oe; endproperty
  a_atn: assert property (p_atn) else $error("attention not driven");
  property p_halt; s_err ##0 is_initiator && !first_scsi_irq_enable_reg[0] |=> halt; endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  property p_defer; s_err ##0 is_target && !is_initiator && second_scsi_control_reg[5] && !halt
    && !transfer_end |=> !halt; endproperty
  a_defer: assert property (p_defer) else $error("halt not deferred");
  property p_mst; clk_en && master_data_phase && target_perr && fourth_chip_test_reg[3] |=>
    dma_status_reg[6] && pci_irq == $past(dma_irq_enable_reg[6]); endproperty
  a_mst: assert property (p_mst) else $error("master parity error wrong");
endmodule
bind spc_parity_ctrl spc_assertions chk (.*);

// ==== test/spc_far_end.sv ====
/* spc_far_end.sv: behavioural scsi peer driving data and parity pins.
   assumes: terminated bus, so released lines sit at the idle high level. */
`timescale 1ns/1ps
module spc_far_end (
  input  wire logic        drive, bad_low, bad_high,
  input  wire logic [15:0] value,
  output wire logic [15:0] data_b,
  output wire logic        low_b, high_b
);
  // odd parity per lane unless the bench asks for a broken lane
  assign data_b = drive ? ~value : 16'hFFFF;
  assign low_b = drive ? ~(~^value[7:0] ^ bad_low) : 1'h1;
  assign high_b = drive ? ~(~^value[15:8] ^ bad_high) : 1'h1;
endmodule

// ==== test/spc_parity_ctrl_bench.sv ====
/* spc_parity_ctrl_bench.sv: self-checking bench for spc_parity_ctrl.
   assumes: spc_far_end stands on the scsi pins; clk_en high except in the freeze test. */
`timescale 1ns/1ps
module spc_parity_ctrl_bench;
  logic clock = 0, rst_b = 0, is_initiator = 0, is_target = 0, wide_bus = 1, transfer_end = 0;
  logic force_bad_parity = 0, tx_valid = 0, rx_strobe = 0, master_data_phase = 0, clk_en = 1;
  logic target_perr = 0, clear_scsi_status = 0, clear_dma_status = 0, drv = 0, blo = 0, bhi = 0;
  logic [7:0] first_scsi_control_reg = '0, second_scsi_control_reg = '0;
  logic [7:0] first_scsi_irq_enable_reg = '0, fourth_chip_test_reg = '0, dma_irq_enable_reg = '0;
  logic [15:0] tx_data = '0, rxd = '0;
  wire [15:0] scsi_data_b_in, scsi_input_latch;
  wire low_lane_check_line_b_in, high_lane_check_line_b_in, low_lane_check_line_b_out;
  wire high_lane_check_line_b_out, check_lines_oe, attention_pin_b_out, attention_pin_oe;
  wire halt, scsi_irq, pci_irq;
  wire [7:0] first_scsi_irq_status_reg, first_scsi_status_reg, second_scsi_status_reg;
  wire [7:0] third_scsi_status_reg, dma_status_reg;
  int n_errors = 0, tests_run = 0;
  always #25 clock = ~clock;
  spc_far_end far (.drive(drv), .bad_low(blo), .bad_high(bhi), .value(rxd),
    .data_b(scsi_data_b_in), .low_b(low_lane_check_line_b_in), .high_b(high_lane_check_line_b_in));
  spc_parity_ctrl dut (.*);
  task automatic chk(input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares=%0d errors=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic flags(input logic [3:0] exp);
    chk({halt, scsi_irq, first_scsi_irq_status_reg[0], attention_pin_b_out}, exp);
  endtask
  // peer sends one transfer; line levels and latch are checked on the way
  task automatic rx(input logic [15:0] v, input logic bl, bh);
    rxd = v; blo = bl; bhi = bh; drv = 1; rx_strobe = 1;
    @(negedge clock);
    rx_strobe = 0; drv = 0;
    chk({third_scsi_status_reg[0], first_scsi_status_reg[0]}, {~^v[15:8] ^ bh, ~^v[7:0] ^ bl});
    chk({third_scsi_status_reg[3], second_scsi_status_reg[3]}, {~^v[15:8], ~^v[7:0]});
    chk(scsi_input_latch, v);
  endtask
  task automatic clear;
    clear_scsi_status = 1; clear_dma_status = 1;
    @(negedge clock);
    clear_scsi_status = 0; clear_dma_status = 0;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    n_errors++;
    wrap_up;
  end
  initial begin
    repeat (6) @(negedge clock);
    chk({halt, pci_irq, dma_status_reg[6], attention_pin_b_out, check_lines_oe}, 5'h02);
    rst_b = 1;
    tx_data = 16'hA53D; tx_valid = 1;
    for (int i = 0; i < 4; i++) begin
      second_scsi_control_reg[2] = i[0]; force_bad_parity = i[1];
      @(negedge clock);
      chk({check_lines_oe, high_lane_check_line_b_out, low_lane_check_line_b_out},
        {1'h1, ^tx_data[15:8] ^ i[0] ^ i[1], ^tx_data[7:0] ^ i[0] ^ i[1]});
    end
    tx_valid = 0; second_scsi_control_reg = '0;
    rx(16'h1234, 1, 0);
    flags(4'h1);
    first_scsi_control_reg = 8'h0A; is_initiator = 1;
    rx(16'h5555, 0, 0);
    flags(4'h1);
    rx(16'h00FF, 1, 0);
    flags(4'hA);
    chk(attention_pin_oe, 1'h1);
    clear;
    first_scsi_irq_enable_reg = 8'h01;
    rx(16'h8001, 0, 1);
    flags(4'h6);
    clear;
    wide_bus = 0;
    rx(16'h8001, 0, 1);
    flags(4'h1);
    is_initiator = 0; is_target = 1; wide_bus = 1;
    first_scsi_irq_enable_reg = '0; second_scsi_control_reg = 8'h20;
    rx(16'h5555, 1, 0);
    flags(4'h3);
    transfer_end = 1;
    @(negedge clock);
    transfer_end = 0;
    chk(halt, 1'h1);
    clear;
    second_scsi_control_reg = '0; first_scsi_irq_enable_reg = 8'h01;
    rx(16'h5555, 1, 0);
    flags(4'hF);
    clear;
    master_data_phase = 1; target_perr = 1;
    @(negedge clock);
    chk({pci_irq, dma_status_reg}, 9'h000);
    fourth_chip_test_reg = 8'h08;
    @(negedge clock);
    chk({pci_irq, dma_status_reg}, 9'h040);
    master_data_phase = 0;
    clear;
    dma_irq_enable_reg = 8'h40; master_data_phase = 1;
    @(negedge clock);
    master_data_phase = 0;
    @(negedge clock);
    chk({pci_irq, dma_status_reg}, 9'h140);
    // with the enable low a clear strobe must not reach the frozen flag
    clk_en = 0; clear_dma_status = 1;
    @(negedge clock);
    chk(dma_status_reg, 8'h40);
    clk_en = 1;
    @(negedge clock);
    clear_dma_status = 0;
    chk(dma_status_reg, 8'h00);
    wrap_up;
  end
endmodule
